// *** core/nco_core.v ***
// Numerically controlled oscillator with APB register slave
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
// Behaviour
// - Each selected input clock edge adds increment into 20-bit accumulator.
// - Accumulator carry forms the raw overflow pulse.
// - Increment held in low, high, upper byte registers, all read/write.
// - Enabled low-byte write loads shadow on second input clock edge.
// - Disabled, any increment write loads the shadow at once.
// - Fixed duty mode toggles output on each overflow.
// - Pulse mode drives output active at edge after overflow, then inactive.
// - Width code sets pulse length 1 to 128 input clock periods.
// - Width longer than overflow spacing leaves output steady.
// - Polarity bit inverts final output and defines active level.
// - Polarity change that moves the output, with module and interrupt mask enabled, raises an interrupt.
// - Read-only status bit shows output; output also goes outward.
// - Each overflow sets the overflow interrupt flag.
// - Interrupt reaches CPU only with enable, mask and both gates set.
// - Reset clears every register to zero.
// - Module runs only while the system clock runs; input clock edges are sampled on it.
// - Enabled with fast oscillator selected keeps that oscillator alive.
// - Clock select 00 fast osc, 01 system clock, 10 logic cell.
// - Control bit 7 enables the module.
// - Control bit 0 selects pulse mode, clear selects fixed duty.
`include "nco_consts.vh"

module nco_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        internal_fast_osc,
  input  wire        logic_cell_one_out,
  output reg         osc_out,
  output reg         irq_to_cpu,
  output reg         fast_osc_keep_on
);

  // Control and configuration state
  reg        on_r;
  reg        inv_r;
  reg        pulse_r;
  reg [2:0]  pws_r;
  reg [1:0]  sel_r;
  reg [19:0] inc_r;
  reg [19:0] shadow_r;
  reg [19:0] acc_r;
  reg        flag_r;
  reg        mask_r;
  reg        periph_r;
  reg        global_r;
  // Input clock edge tracking
  reg        fast_prev_r;
  reg        cell_prev_r;
  // Shadow transfer sequencing
  reg [1:0]  pend_r;
  reg        imm_r;
  // Output shaping
  reg        raw_r;
  reg        ovf_r;
  reg [6:0]  cnt_r;
  reg        inv_prev_r;

  // Internal strobes and datapath
  wire        wr_en;
  wire        rd_en;
  wire        tick;
  wire [20:0] sum;
  wire        carry;
  wire        out_nxt;
  wire [6:0]  width_m1;
  wire        wr_acc_l;
  wire        wr_acc_h;
  wire        wr_acc_u;
  wire        flag_clr;
  wire        pol_irq;
  reg         tick_sel;
  reg  [31:0] rd_nxt;
  reg         hit;

  // Pulse length minus one for a width code
  function [6:0] nco_width_m1;
    input [2:0] code;
    begin
      nco_width_m1 = (7'h01 << code) - 7'h01;
    end
  endfunction

  // Decode an address into a hit flag
  function nco_mapped;
    input [7:0] a;
    begin
      case (a)
        `NCO_ADDR_CTRL,
        `NCO_ADDR_CLK,
        `NCO_ADDR_ACC_L,
        `NCO_ADDR_ACC_H,
        `NCO_ADDR_ACC_U,
        `NCO_ADDR_INC_L,
        `NCO_ADDR_INC_H,
        `NCO_ADDR_INC_U,
        `NCO_ADDR_IRQ_FLG,
        `NCO_ADDR_IRQ_MSK,
        `NCO_ADDR_IRQ_MAIN: nco_mapped = 1'b1;
        default: nco_mapped = 1'b0;
      endcase
    end
  endfunction

  // Access completes on the second access cycle
  assign wr_en = psel & penable & pready & pwrite;
  assign rd_en = psel & penable & ~pready & ~pwrite;

  // Accumulator byte write strobes and interrupt flag clear strobe
  assign wr_acc_l = wr_en & (paddr == `NCO_ADDR_ACC_L);
  assign wr_acc_h = wr_en & (paddr == `NCO_ADDR_ACC_H);
  assign wr_acc_u = wr_en & (paddr == `NCO_ADDR_ACC_U);
  assign flag_clr = wr_en & (paddr == `NCO_ADDR_IRQ_FLG) &
                    ~pwdata[`NCO_IRQ_BIT];

  always @* begin
    case (sel_r)
      `NCO_SEL_FAST: tick_sel = internal_fast_osc & ~fast_prev_r;
      `NCO_SEL_SYS:  tick_sel = 1'b1;
      `NCO_SEL_CELL: tick_sel = logic_cell_one_out & ~cell_prev_r;
      default:       tick_sel = 1'b0;
    endcase
  end

  assign tick = tick_sel & on_r;

  assign sum      = {1'b0, acc_r} + {1'b0, shadow_r};
  assign carry    = tick & sum[20];
  assign width_m1 = nco_width_m1(pws_r);
  assign out_nxt  = raw_r ^ inv_r;
  // polarity change that moves the output
  assign pol_irq  = mask_r & on_r & (inv_r != inv_prev_r) &
                    (out_nxt != osc_out);

  // Read data mux
  always @* begin
    rd_nxt = 32'h00000000;
    hit    = nco_mapped(paddr);
    case (paddr)
      `NCO_ADDR_CTRL: rd_nxt[7:0] = {on_r, 1'b0, osc_out, inv_r,
                                     3'h0, pulse_r};
      `NCO_ADDR_CLK:  rd_nxt[7:0] = {pws_r, 3'h0, sel_r};
      `NCO_ADDR_ACC_L: rd_nxt[7:0] = acc_r[7:0];
      `NCO_ADDR_ACC_H: rd_nxt[7:0] = acc_r[15:8];
      `NCO_ADDR_ACC_U: rd_nxt[3:0] = acc_r[19:16];
      `NCO_ADDR_INC_L: rd_nxt[7:0] = inc_r[7:0];
      `NCO_ADDR_INC_H: rd_nxt[7:0] = inc_r[15:8];
      `NCO_ADDR_INC_U: rd_nxt[3:0] = inc_r[19:16];
      `NCO_ADDR_IRQ_FLG: rd_nxt[`NCO_IRQ_BIT] = flag_r;
      `NCO_ADDR_IRQ_MSK: rd_nxt[`NCO_IRQ_BIT] = mask_r;
      `NCO_ADDR_IRQ_MAIN: begin
        rd_nxt[`NCO_GLOBAL_BIT] = global_r;
        rd_nxt[`NCO_PERIPH_BIT] = periph_r;
      end
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // APB handshake and read capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      if (rd_en) begin
        prdata <= rd_nxt;
      end
    end
  end

  // all registers clear on reset
  // Software registers and shadow transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r     <= 1'b0;
      inv_r    <= 1'b0;
      pulse_r  <= 1'b0;
      pws_r    <= 3'h0;
      sel_r    <= 2'h0;
      inc_r    <= `NCO_RST_ACC;
      shadow_r <= `NCO_RST_ACC;
      mask_r   <= 1'b0;
      periph_r <= 1'b0;
      global_r <= 1'b0;
      pend_r   <= 2'h0;
      imm_r    <= 1'b0;
    end else begin
      imm_r <= 1'b0;
      // two-edge transfer after low byte write
      if (tick && pend_r != 2'h0) begin
        pend_r <= pend_r - 2'h1;
        if (pend_r == 2'h1) begin
          shadow_r <= inc_r;
        end
      end
      if (imm_r) begin
        shadow_r <= inc_r;
      end
      if (wr_en) begin
        case (paddr)
          `NCO_ADDR_CTRL: begin
            on_r    <= pwdata[`NCO_CTRL_ON];
            inv_r   <= pwdata[`NCO_CTRL_INV];
            pulse_r <= pwdata[`NCO_CTRL_PULSE];
          end
          `NCO_ADDR_CLK: begin
            pws_r <= pwdata[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
            sel_r <= pwdata[`NCO_CLK_SEL_HI:`NCO_CLK_SEL_LO];
          end
          `NCO_ADDR_INC_L: begin
            inc_r[7:0] <= pwdata[7:0];
            imm_r      <= ~on_r;
            if (on_r) begin
              pend_r <= `NCO_LOAD_EDGES;
            end
          end
          `NCO_ADDR_INC_H: begin
            inc_r[15:8] <= pwdata[7:0];
            imm_r       <= ~on_r;
          end
          `NCO_ADDR_INC_U: begin
            inc_r[19:16] <= pwdata[3:0];
            imm_r        <= ~on_r;
          end
          `NCO_ADDR_IRQ_MSK: mask_r <= pwdata[`NCO_IRQ_BIT];
          `NCO_ADDR_IRQ_MAIN: begin
            global_r <= pwdata[`NCO_GLOBAL_BIT];
            periph_r <= pwdata[`NCO_PERIPH_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Input clock history for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_prev_r <= 1'b0;
      cell_prev_r <= 1'b0;
    end else begin
      fast_prev_r <= internal_fast_osc;
      cell_prev_r <= logic_cell_one_out;
    end
  end

  // Accumulator; a software write wins over an addition
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= `NCO_RST_ACC;
    end else begin
      if (wr_acc_l) begin
        acc_r[7:0] <= pwdata[7:0];
      end else if (wr_acc_h) begin
        acc_r[15:8] <= pwdata[7:0];
      end else if (wr_acc_u) begin
        acc_r[19:16] <= pwdata[3:0];
      end else if (tick) begin
        acc_r <= sum[19:0];
      end
    end
  end

  // Output shaping in both modes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_r <= 1'b0;
      ovf_r <= 1'b0;
      cnt_r <= 7'h00;
    end else if (tick) begin
      ovf_r <= carry;
      if (!pulse_r) begin
        if (carry) begin
          raw_r <= ~raw_r;
        end
      end else if (ovf_r) begin
        // new overflow restarts, output stays active
        raw_r <= 1'b1;
        cnt_r <= width_m1;
      end else if (raw_r && cnt_r == 7'h00) begin
        raw_r <= 1'b0;
      end else if (raw_r) begin
        cnt_r <= cnt_r - 7'h01;
      end
    end
  end

  // Polarity history for change detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_prev_r <= 1'b0;
    end else begin
      inv_prev_r <= inv_r;
    end
  end

  // Overflow flag; set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else begin
      // flag holds until software writes zero
      if (flag_clr) begin
        flag_r <= 1'b0;
      end
      if (carry || pol_irq) begin
        flag_r <= 1'b1;
      end
    end
  end

  // four-way gate, one cycle behind flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_to_cpu <= 1'b0;
    end else begin
      irq_to_cpu <= flag_r & on_r & mask_r & periph_r & global_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_out <= 1'b0;
    end else begin
      osc_out <= out_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_keep_on <= 1'b0;
    end else begin
      fast_osc_keep_on <= on_r & (sel_r == `NCO_SEL_FAST);
    end
  end

endmodule // nco_core

// *** shared/nco_consts.vh ***
// Constants for the numerically controlled oscillator block
`ifndef NCO_CONSTS_VH
`define NCO_CONSTS_VH

// Register byte addresses on the APB
`define NCO_ADDR_CTRL    8'h00
`define NCO_ADDR_CLK     8'h04
`define NCO_ADDR_ACC_L   8'h08
`define NCO_ADDR_ACC_H   8'h0C
`define NCO_ADDR_ACC_U   8'h10
`define NCO_ADDR_INC_L   8'h14
`define NCO_ADDR_INC_H   8'h18
`define NCO_ADDR_INC_U   8'h1C
`define NCO_ADDR_IRQ_FLG 8'h20
`define NCO_ADDR_IRQ_MSK 8'h24
`define NCO_ADDR_IRQ_MAIN 8'h28

// Field positions in osc_control
`define NCO_CTRL_ON      7
`define NCO_CTRL_VIEW    5
`define NCO_CTRL_INV     4
`define NCO_CTRL_PULSE   0

// Field positions in osc_input_clock_control
`define NCO_CLK_PWS_HI   7
`define NCO_CLK_PWS_LO   5
`define NCO_CLK_SEL_HI   1
`define NCO_CLK_SEL_LO   0

// Field positions in the interrupt registers
`define NCO_IRQ_BIT      0
`define NCO_GLOBAL_BIT   7
`define NCO_PERIPH_BIT   6

// Clock select codes
`define NCO_SEL_FAST     2'h0
`define NCO_SEL_SYS      2'h1
`define NCO_SEL_CELL     2'h2

// Reset values
`define NCO_RST_BYTE     8'h00
`define NCO_RST_ACC      20'h00000

// Increment buffer transfer delay, in input clock edges
`define NCO_LOAD_EDGES   2'h2

`endif

// *** verif/nopa_checker_assertions.sv ***
// Port checker for the oscillator block
`timescale 1ns/10ps
`include "nco_consts.vh"
module nopa_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        osc_out,
  input wire        irq_to_cpu,
  input wire        fast_osc_keep_on
);
  reg  [7:0] ctl_r;
  reg  [1:0] sel_r;
  reg  [2:0] irq_r;
  wire       wr   = psel & penable & pready & pwrite;
  wire       keep = ctl_r[7] & (sel_r == `NCO_SEL_FAST);
  wire       gate = ctl_r[7] & (&irq_r);
  wire       hold = ctl_r[7] & (sel_r == 2'h3);
  // Shadow of the written control fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= 8'h00;
      sel_r <= 2'h0;
      irq_r <= 3'h0;
    end else if (wr) begin
      if (paddr == `NCO_ADDR_CTRL) ctl_r <= pwdata[7:0];
      if (paddr == `NCO_ADDR_CLK) sel_r <= pwdata[1:0];
      if (paddr == `NCO_ADDR_IRQ_MSK) irq_r[0] <= pwdata[0];
      if (paddr == `NCO_ADDR_IRQ_MAIN) irq_r[2:1] <= pwdata[7:6];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0 |->
    pslverr == (paddr > `NCO_ADDR_IRQ_MAIN))
    else $error("pslverr wrong for address");
  status_bit_a: assert property (pready && !pwrite &&
    paddr == `NCO_ADDR_CTRL && $stable(osc_out) |-> prdata[5] == osc_out)
    else $error("status bit differs from output");
  keep_osc_a: assert property (keep [*2] |-> fast_osc_keep_on)
    else $error("fast oscillator not kept on");
  keep_off_a: assert property (!keep [*2] |-> !fast_osc_keep_on)
    else $error("fast oscillator kept on wrongly");
  irq_gate_a: assert property (!gate [*2] |-> !irq_to_cpu)
    else $error("interrupt passed a closed gate");
  reserved_hold_a: assert property ((hold && $stable(ctl_r[4])) [*3]
    |-> $stable(osc_out))
    else $error("output moved with no clock");
  reset_clear_a: assert property ($rose(presetn) |-> !osc_out &&
    !irq_to_cpu && !fast_osc_keep_on && !pready)
    else $error("outputs not clear after reset");
endmodule // nopa_checker

bind nco_core nopa_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_out(osc_out),
  .irq_to_cpu(irq_to_cpu), .fast_osc_keep_on(fast_osc_keep_on));

// *** verif/numeric_osc_phase_accumulator_test.sv ***
// Self-checking bench for the oscillator block
`timescale 1ns/10ps
`include "nco_consts.vh"
module numeric_osc_phase_accumulator_test;
  reg          pclk, presetn, psel, penable, pwrite, fosc, lcell;
  reg  [7:0]   paddr;
  reg  [31:0]  pwdata;
  wire [31:0]  prdata;
  wire         pready, pslverr, osc_out, irq_to_cpu, keep;
  int          n_mismatch, comparisons, i, w;
  logic [33:0] expq[$];
  logic [19:0] r1, r2, acc;

  nco_core uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_fast_osc(fosc),
    .logic_cell_one_out(lcell), .osc_out(osc_out),
    .irq_to_cpu(irq_to_cpu), .fast_osc_keep_on(keep));

  // Clock and a fast oscillator of six clocks a period
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    fosc = 0;
    forever begin
      repeat (3) @(posedge pclk);
      fosc <= ~fosc;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // One bus transfer; the expected answer goes to the queue
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err = 1'b0);
    int n;
    expq.push_back({wr, err, d});
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) n_mismatch++;
    psel <= 0;
    penable <= 0;
  endtask

  // Compares each completed transfer with the oldest note
  always @(posedge pclk) begin : mon
    logic [33:0] e;
    if (psel && penable && pready === 1'b1) begin
      e = expq.pop_front();
      chk("pslverr", e[32], pslverr);
      if (!e[33]) chk("prdata", e[31:0], prdata);
    end
  end

  task automatic inc(input logic [19:0] v);
    apb(1, `NCO_ADDR_INC_U, 32'(v[19:16]));
    apb(1, `NCO_ADDR_INC_H, 32'(v[15:8]));
    apb(1, `NCO_ADDR_INC_L, 32'(v[7:0]));
  endtask

  task automatic rd3(input logic [7:0] a, input logic [19:0] v);
    apb(0, a, 32'(v[7:0]));
    apb(0, 8'(a + 8'h04), 32'(v[15:8]));
    apb(0, 8'(a + 8'h08), 32'(v[19:16]));
  endtask

  task automatic cfg(input logic [7:0] c, k, input logic [19:0] v);
    apb(1, `NCO_ADDR_CTRL, 0);
    inc(v);
    apb(1, `NCO_ADDR_CLK, 32'(k));
    apb(1, `NCO_ADDR_CTRL, 32'(c));
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge pclk) lcell <= 1;
      repeat (2) @(posedge pclk);
      lcell <= 0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // Length of the next active phase of the output
  task automatic width(input logic act, input int e);
    int n;
    for (n = 0; n < 2000 && osc_out === act; n++) @(posedge pclk);
    for (n = 0; n < 2000 && osc_out !== act; n++) @(posedge pclk);
    for (n = 0; n < 300 && osc_out === act; n++) @(posedge pclk);
    chk("width", e, n);
  endtask

  task automatic irq(input logic e);
    repeat (3) @(posedge pclk);
    chk("irq_to_cpu", e, irq_to_cpu);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end

  initial begin
    {presetn, psel, penable, pwrite, lcell} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    void'($urandom(32'h47A9));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i <= 'h2C; i += 4)
      apb(0, i[7:0], 0, i > 'h28);
    $display("test reset_values done");
    r1 = 20'($urandom);
    r2 = 20'($urandom);
    cfg(8'h80, 8'h02, r1);
    tick(3);
    acc = 20'(3 * r1);
    rd3(`NCO_ADDR_ACC_L, acc);
    inc(r2);
    tick(4);
    acc = 20'(acc + 2 * r1 + 2 * r2);
    rd3(`NCO_ADDR_ACC_L, acc);
    rd3(`NCO_ADDR_INC_L, r2);
    $display("test increment done");
    for (i = 0; i < 8; i++) begin
      cfg({3'h4, i[0], 4'h1}, {i[2:0], 5'h01}, 20'h00800);
      width(~i[0], 1 << i);
    end
    $display("test pulse_width done");
    cfg(8'h80, 8'h01, 20'h40000);
    width(1, 4);
    chk("keep", 0, keep);
    cfg(8'h80, 8'h00, 20'h40000);
    width(1, 24);
    chk("keep", 1, keep);
    $display("test fixed_duty done");
    cfg(8'h81, 8'hE1, 20'h40000);
    repeat (20) @(posedge pclk);
    w = 0;
    repeat (200) @(posedge pclk) w += osc_out;
    chk("steady", 200, w);
    apb(0, `NCO_ADDR_IRQ_FLG, 1);
    $display("test overflow done");
    cfg(8'h80, 8'h03, 20'h40000);
    apb(1, `NCO_ADDR_IRQ_FLG, 0);
    apb(1, `NCO_ADDR_IRQ_MSK, 1);
    apb(1, `NCO_ADDR_IRQ_MAIN, 8'hC0);
    apb(0, `NCO_ADDR_IRQ_FLG, 0);
    irq(0);
    apb(1, `NCO_ADDR_CTRL, 8'h90);
    apb(0, `NCO_ADDR_IRQ_FLG, 1);
    irq(1);
    apb(1, `NCO_ADDR_IRQ_MAIN, 8'h80);
    irq(0);
    apb(1, `NCO_ADDR_IRQ_MAIN, 8'hC0);
    irq(1);
    apb(1, `NCO_ADDR_IRQ_FLG, 0);
    irq(0);
    $display("test interrupt done");
    wrap_up;
  end
endmodule // numeric_osc_phase_accumulator_test
